// file: rtl/mid_map.svh
// register offsets, field positions, reset values and timing figures of the detector
`ifndef MID_MAP_SVH
`define MID_MAP_SVH

`define MID_ADDR_Z_MOTION_LOW   8'h28
`define MID_ADDR_MOTION_DUR     8'h29
`define MID_ADDR_X_STILL_HIGH   8'h2A
`define MID_ADDR_X_STILL_LOW    8'h2B
`define MID_ADDR_Y_STILL_HIGH   8'h2C
`define MID_ADDR_Y_STILL_LOW    8'h2D
`define MID_ADDR_Z_STILL_HIGH   8'h2E

`define MID_LIM_LSB_HI          7
`define MID_LIM_LSB_LO          5
`define MID_REF_BIT             1
`define MID_USE_BIT             0

`define MID_MASK_LIM_USE        8'hE1
`define MID_MASK_LIM_REF_USE    8'hE3
`define MID_REG_RESET           8'h00

`define MID_CLK_NS              25.0
`define MID_MOTION_FAST_MS      4.125
`define MID_MOTION_SLOW_MS      8.25
`define MID_STILL_FAST_MS       16.25
`define MID_STILL_SLOW_MS       32.5
`define MID_CYCLES(ms)          (int'((ms) * 1000000.0 / `MID_CLK_NS))

`endif

// file: rtl/mid_pkg.sv
// types and arithmetic shared by the detector files
package mid_pkg;

  typedef logic signed [11:0] mid_sample_t;
  typedef logic [10:0]        mid_limit_t;

  typedef enum logic [2:0] {
    MID_ACT_IDLE  = 3'b001,
    MID_MOTION_DURATION_COUNT = 3'b010,
    MID_ACT_HELD  = 3'b100
  } mid_act_state_t;

  typedef enum logic [2:0] {
    MID_STILL_IDLE  = 3'b001,
    MID_STILL_COUNT = 3'b010,
    MID_STILL_HELD  = 3'b100
  } mid_still_state_t;

  // magnitude of a sample, or of its distance from a base sample
  function automatic logic [12:0] mid_abs_diff(input mid_sample_t a,
                                               input mid_sample_t b,
                                               input logic        use_b);
    logic signed [12:0] d;
    d = $signed({a[11], a}) - (use_b ? $signed({b[11], b}) : 13'sh0000);
    return d[12] ? 13'(-d) : 13'(d);
  endfunction

endpackage

// file: rtl/mid_axis_cmp.sv
// one axis: magnitude against an unsigned 11-bit limit
module mid_axis_cmp (
  input  wire mid_pkg::mid_sample_t sample,
  input  wire mid_pkg::mid_sample_t base_sample,
  input  wire logic                 use_base,
  input  wire mid_pkg::mid_limit_t  limit,
  output logic                      above,
  output logic                      below
);
  logic [12:0] mag;

  assign mag   = mid_pkg::mid_abs_diff(sample, base_sample, use_base);
  assign above = mag > {2'b00, limit};
  assign below = mag < {2'b00, limit};
endmodule

// file: rtl/mid_code_tick.sv
// one-cycle enable per duration code, period picked by the sample rate
module mid_code_tick #(
  parameter int unsigned FAST_CYC = 2,
  parameter int unsigned SLOW_CYC = 4
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic fast,
  input  wire logic clear,
  output logic      tick
);
  localparam int unsigned W = $clog2(SLOW_CYC + 1);

  logic [W-1:0] cnt;
  logic [W-1:0] last;

  assign last = fast ? W'(FAST_CYC - 1) : W'(SLOW_CYC - 1);
  // >= so a rate change mid-count cannot strand the counter past the end
  assign tick = !clear && (cnt >= last);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if (clear || tick)
      cnt <= '0;
    else
      cnt <= cnt + W'(1);
  end

  tick_gap_a: assert property (@(posedge clk) disable iff (!rstn) tick |=> !tick)
    else $error("code tick repeated on consecutive cycles");
endmodule

// file: rtl/mid_detect_core.sv
// activity and inactivity configuration registers with the detectors they steer
`include "mid_map.svh"

// Overview of operation
// - z activity limit low bits at 0x28[7:5]
// - 0x28 bit0 enables z axis for activity
// - activity needs above-limit motion for full duration
// - fast rate: one duration code is 4.125 ms
// - slower rates: one duration code is 8.25 ms
// - activity duration is 8-bit register 0x29
// - inactivity limits are 11-bit, 200 mg codes
// - compare sample magnitude against unsigned limit
// - x still limit from 0x2A and 0x2B[7:5]
// - 0x2B bit1 selects referenced or absolute inactivity
// - 0x2B bit0 enables x axis for inactivity
// - 0x2D bit0 enables y axis for inactivity
// - y still limit from 0x2C and 0x2D[7:5]
// - z still limit high byte is 0x2E
// - every register reads zero after reset
// - inactivity needs all enabled axes below, full time
// - activity limit 11-bit, magnitude compared
module mid_detect_core #(
  parameter int unsigned MOTION_FAST_CYC = `MID_CYCLES(`MID_MOTION_FAST_MS),
  parameter int unsigned MOTION_SLOW_CYC = `MID_CYCLES(`MID_MOTION_SLOW_MS),
  parameter int unsigned STILL_FAST_CYC  = `MID_CYCLES(`MID_STILL_FAST_MS),
  parameter int unsigned STILL_SLOW_CYC  = `MID_CYCLES(`MID_STILL_SLOW_MS)
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RSTN,
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [7:0]           REG_RDATA,
  input  wire logic                 OUTPUT_SAMPLE_RATE_FAST,
  input  wire logic [7:0]           Z_MOTION_LIMIT_HIGH,
  input  wire logic                 XY_MOTION_OVER,
  input  wire logic [2:0]           Z_STILL_LIMIT_LOW,
  input  wire logic                 Z_STILL_AXIS_USE,
  input  wire logic [15:0]          STILL_DURATION_VALUE,
  input  wire logic                 SAMPLE_VALID,
  input  wire mid_pkg::mid_sample_t X_SAMPLE,
  input  wire mid_pkg::mid_sample_t Y_SAMPLE,
  input  wire mid_pkg::mid_sample_t Z_SAMPLE,
  output logic                      ACTIVITY_EVENT,
  output logic                      INACTIVITY_EVENT,
  output logic                      MOTION_ACTIVE,
  output logic                      STILL_ACTIVE
);
  logic [7:0]                z_motion_low;
  logic [7:0]                motion_duration_reg;
  logic [7:0]                x_still_high;
  logic [7:0]                x_still_low;
  logic [7:0]                y_still_high;
  logic [7:0]                y_still_low;
  logic [7:0]                z_still_high;
  mid_pkg::mid_limit_t       z_motion_limit;
  mid_pkg::mid_limit_t       x_still_limit;
  mid_pkg::mid_limit_t       y_still_limit;
  mid_pkg::mid_limit_t       z_still_limit;
  logic                      z_motion_axis_use;
  logic                      x_still_axis_use;
  logic                      y_still_axis_use;
  logic                      still_reference_select;
  logic                      z_motion_over;
  logic                      motion_over;
  logic                      x_below;
  logic                      y_below;
  logic                      z_below;
  logic                      still_any;
  logic                      all_below;
  mid_pkg::mid_sample_t      x_base;
  mid_pkg::mid_sample_t      y_base;
  mid_pkg::mid_sample_t      z_base;
  mid_pkg::mid_act_state_t   act_state;
  mid_pkg::mid_still_state_t still_state;
  logic [7:0]                motion_duration_count;
  logic [7:0]                next_motion_count;
  logic [15:0]               still_count;
  logic [15:0]               next_still_count;
  logic                      act_tick;
  logic                      still_tick;
  logic [19:0]               act_cyc;

  assign z_motion_limit    = {Z_MOTION_LIMIT_HIGH, z_motion_low[`MID_LIM_LSB_HI:`MID_LIM_LSB_LO]};
  assign z_motion_axis_use = z_motion_low[`MID_USE_BIT];
  assign x_still_limit = {x_still_high, x_still_low[`MID_LIM_LSB_HI:`MID_LIM_LSB_LO]};
  assign y_still_limit = {y_still_high, y_still_low[`MID_LIM_LSB_HI:`MID_LIM_LSB_LO]};
  assign z_still_limit = {z_still_high, Z_STILL_LIMIT_LOW};
  assign still_reference_select = x_still_low[`MID_REF_BIT];
  assign x_still_axis_use       = x_still_low[`MID_USE_BIT];
  assign y_still_axis_use       = y_still_low[`MID_USE_BIT];

  // register writes; reserved positions are masked off so they read zero
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      z_motion_low        <= `MID_REG_RESET;
      motion_duration_reg <= `MID_REG_RESET;
      x_still_high        <= `MID_REG_RESET;
      x_still_low         <= `MID_REG_RESET;
      y_still_high        <= `MID_REG_RESET;
      y_still_low         <= `MID_REG_RESET;
      z_still_high        <= `MID_REG_RESET;
    end
    else if (REG_WR)
    begin
      unique case (REG_ADDR)
        `MID_ADDR_Z_MOTION_LOW: z_motion_low        <= REG_WDATA & `MID_MASK_LIM_USE;
        `MID_ADDR_MOTION_DUR:   motion_duration_reg <= REG_WDATA;
        `MID_ADDR_X_STILL_HIGH: x_still_high        <= REG_WDATA;
        `MID_ADDR_X_STILL_LOW:  x_still_low         <= REG_WDATA & `MID_MASK_LIM_REF_USE;
        `MID_ADDR_Y_STILL_HIGH: y_still_high        <= REG_WDATA;
        `MID_ADDR_Y_STILL_LOW:  y_still_low         <= REG_WDATA & `MID_MASK_LIM_USE;
        `MID_ADDR_Z_STILL_HIGH: z_still_high        <= REG_WDATA;
        default:                z_motion_low        <= z_motion_low;
      endcase
    end
  end

  // read data registered; other addresses belong to neighbouring blocks and read zero here
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      REG_RDATA <= `MID_REG_RESET;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        `MID_ADDR_Z_MOTION_LOW: REG_RDATA <= z_motion_low;
        `MID_ADDR_MOTION_DUR:   REG_RDATA <= motion_duration_reg;
        `MID_ADDR_X_STILL_HIGH: REG_RDATA <= x_still_high;
        `MID_ADDR_X_STILL_LOW:  REG_RDATA <= x_still_low;
        `MID_ADDR_Y_STILL_HIGH: REG_RDATA <= y_still_high;
        `MID_ADDR_Y_STILL_LOW:  REG_RDATA <= y_still_low;
        `MID_ADDR_Z_STILL_HIGH: REG_RDATA <= z_still_high;
        default:                REG_RDATA <= `MID_REG_RESET;
      endcase
    end
  end

  // activity is always absolute; only the still path can be referenced
  mid_axis_cmp u_z_motion (
    .sample      (Z_SAMPLE),
    .base_sample (12'sh000),
    .use_base    (1'b0),
    .limit       (z_motion_limit),
    .above       (z_motion_over),
    .below       ()
  );

  mid_axis_cmp u_x_still (
    .sample      (X_SAMPLE),
    .base_sample (x_base),
    .use_base    (still_reference_select),
    .limit       (x_still_limit),
    .above       (),
    .below       (x_below)
  );

  mid_axis_cmp u_y_still (
    .sample      (Y_SAMPLE),
    .base_sample (y_base),
    .use_base    (still_reference_select),
    .limit       (y_still_limit),
    .above       (),
    .below       (y_below)
  );

  mid_axis_cmp u_z_still (
    .sample      (Z_SAMPLE),
    .base_sample (z_base),
    .use_base    (still_reference_select),
    .limit       (z_still_limit),
    .above       (),
    .below       (z_below)
  );

  assign motion_over = (z_motion_axis_use && z_motion_over) || XY_MOTION_OVER;
  // with no axis enabled inactivity can never be reported
  assign still_any = x_still_axis_use || y_still_axis_use || Z_STILL_AXIS_USE;
  assign all_below = still_any && (!x_still_axis_use || x_below)
                     && (!y_still_axis_use || y_below)
                     && (!Z_STILL_AXIS_USE || z_below);

  mid_code_tick #(
    .FAST_CYC (MOTION_FAST_CYC),
    .SLOW_CYC (MOTION_SLOW_CYC)
  ) u_act_tick (
    .clk   (SYS_CLK),
    .rstn  (RSTN),
    .fast  (OUTPUT_SAMPLE_RATE_FAST),
    .clear (act_state != mid_pkg::MID_MOTION_DURATION_COUNT),
    .tick  (act_tick)
  );

  mid_code_tick #(
    .FAST_CYC (STILL_FAST_CYC),
    .SLOW_CYC (STILL_SLOW_CYC)
  ) u_still_tick (
    .clk   (SYS_CLK),
    .rstn  (RSTN),
    .fast  (OUTPUT_SAMPLE_RATE_FAST),
    .clear (still_state != mid_pkg::MID_STILL_COUNT),
    .tick  (still_tick)
  );

  assign next_motion_count = motion_duration_count + 8'h01;
  assign next_still_count  = still_count + 16'h0001;
  assign MOTION_ACTIVE     = act_state == mid_pkg::MID_ACT_HELD;
  assign STILL_ACTIVE      = still_state == mid_pkg::MID_STILL_HELD;

  // activity: a zero duration fires on the first over-limit sample
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      act_state             <= mid_pkg::MID_ACT_IDLE;
      motion_duration_count <= 8'h00;
      ACTIVITY_EVENT        <= 1'b0;
    end
    else
    begin
      ACTIVITY_EVENT <= 1'b0;
      unique case (act_state)
        mid_pkg::MID_ACT_IDLE:
          if (SAMPLE_VALID && motion_over)
          begin
            motion_duration_count <= 8'h00;
            if (motion_duration_reg == 8'h00)
            begin
              ACTIVITY_EVENT <= 1'b1;
              act_state      <= mid_pkg::MID_ACT_HELD;
            end
            else
              act_state <= mid_pkg::MID_MOTION_DURATION_COUNT;
          end
        mid_pkg::MID_MOTION_DURATION_COUNT:
          if (SAMPLE_VALID && !motion_over)
            act_state <= mid_pkg::MID_ACT_IDLE;
          else if (act_tick)
          begin
            motion_duration_count <= next_motion_count;
            if (next_motion_count >= motion_duration_reg)
            begin
              ACTIVITY_EVENT <= 1'b1;
              act_state      <= mid_pkg::MID_ACT_HELD;
            end
          end
        mid_pkg::MID_ACT_HELD:
          if (SAMPLE_VALID && !motion_over)
            act_state <= mid_pkg::MID_ACT_IDLE;
      endcase
    end
  end

  // referenced mode: base follows the samples until a still period starts
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      x_base <= 12'sh000;
      y_base <= 12'sh000;
      z_base <= 12'sh000;
    end
    else if (SAMPLE_VALID && still_state == mid_pkg::MID_STILL_IDLE)
    begin
      x_base <= X_SAMPLE;
      y_base <= Y_SAMPLE;
      z_base <= Z_SAMPLE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      still_state      <= mid_pkg::MID_STILL_IDLE;
      still_count      <= 16'h0000;
      INACTIVITY_EVENT <= 1'b0;
    end
    else
    begin
      INACTIVITY_EVENT <= 1'b0;
      unique case (still_state)
        mid_pkg::MID_STILL_IDLE:
          if (SAMPLE_VALID && all_below)
          begin
            still_count <= 16'h0000;
            if (STILL_DURATION_VALUE == 16'h0000)
            begin
              INACTIVITY_EVENT <= 1'b1;
              still_state      <= mid_pkg::MID_STILL_HELD;
            end
            else
              still_state <= mid_pkg::MID_STILL_COUNT;
          end
        mid_pkg::MID_STILL_COUNT:
          if (SAMPLE_VALID && !all_below)
            still_state <= mid_pkg::MID_STILL_IDLE;
          else if (still_tick)
          begin
            still_count <= next_still_count;
            if (next_still_count >= STILL_DURATION_VALUE)
            begin
              INACTIVITY_EVENT <= 1'b1;
              still_state      <= mid_pkg::MID_STILL_HELD;
            end
          end
        mid_pkg::MID_STILL_HELD:
          if (SAMPLE_VALID && !all_below)
            still_state <= mid_pkg::MID_STILL_IDLE;
      endcase
    end
  end

  // helper for checks: cycles in the counting state since entry or the last code tick
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      act_cyc <= 20'h00000;
    else if (act_state != mid_pkg::MID_MOTION_DURATION_COUNT || act_tick)
      act_cyc <= 20'h00000;
    else
      act_cyc <= act_cyc + 20'h00001;
  end

  default clocking mid_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  z_limit_write_a: assert property (
    REG_WR && REG_ADDR == `MID_ADDR_Z_MOTION_LOW
    |=> z_motion_limit[2:0] == $past(REG_WDATA[7:5]))
    else $error("z activity limit low bits not taken from write");
  z_use_gate_a: assert property (
    act_state == mid_pkg::MID_ACT_IDLE && !z_motion_axis_use && !XY_MOTION_OVER
    |=> act_state == mid_pkg::MID_ACT_IDLE)
    else $error("disabled z axis started activity timing");
  act_sustain_a: assert property (
    ACTIVITY_EVENT && $past(motion_duration_reg) != 8'h00
    |-> $past(act_state) == mid_pkg::MID_MOTION_DURATION_COUNT && $past(act_tick))
    else $error("activity flagged without a completed duration code");
  fast_code_a: assert property (
    act_tick && OUTPUT_SAMPLE_RATE_FAST
    |-> act_cyc == 20'(MOTION_FAST_CYC - 1))
    else $error("fast activity code period wrong");
  slow_code_a: assert property (
    act_tick && !OUTPUT_SAMPLE_RATE_FAST
    |-> act_cyc == 20'(MOTION_SLOW_CYC - 1))
    else $error("slow activity code period wrong");
  dur_readback_a: assert property (
    REG_WR && REG_ADDR == `MID_ADDR_MOTION_DUR ##1 !REG_WR
    ##1 REG_RD && REG_ADDR == `MID_ADDR_MOTION_DUR
    |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("activity duration did not read back");
  x_limit_write_a: assert property (
    REG_WR && REG_ADDR == `MID_ADDR_X_STILL_HIGH |=> x_still_limit[10:3] == $past(REG_WDATA))
    else $error("x still limit high byte not taken");
  ref_select_a: assert property (
    REG_WR && REG_ADDR == `MID_ADDR_X_STILL_LOW
    |=> still_reference_select == $past(REG_WDATA[1]))
    else $error("reference select not taken from write");
  y_use_write_a: assert property (
    REG_WR && REG_ADDR == `MID_ADDR_Y_STILL_LOW |=> y_still_axis_use == $past(REG_WDATA[0]))
    else $error("y still enable not taken from write");
  z_high_write_a: assert property (
    REG_WR && REG_ADDR == `MID_ADDR_Z_STILL_HIGH |=> z_still_limit[10:3] == $past(REG_WDATA))
    else $error("z still limit high byte not taken");
  still_any_a: assert property (
    INACTIVITY_EVENT |-> $past(still_any))
    else $error("inactivity reported with no axis enabled");
  rsvd_zero_a: assert property (
    REG_RD && REG_ADDR == `MID_ADDR_Y_STILL_LOW |=> REG_RDATA[4:1] == 4'h0)
    else $error("reserved bits read nonzero");

  act_timed_c: cover property (ACTIVITY_EVENT && motion_duration_reg != 8'h00);
  still_fired_c: cover property (INACTIVITY_EVENT && STILL_DURATION_VALUE != 16'h0000);
  still_ref_c: cover property (INACTIVITY_EVENT && still_reference_select);
  act_abort_c: cover property (act_state == mid_pkg::MID_MOTION_DURATION_COUNT ##1
                               act_state == mid_pkg::MID_ACT_IDLE);
endmodule

// file: sim/mid_host_model.sv
// host model: register writes and reads over the strobe port
module mid_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // gap idles the host; released lines show the inverse, never a stale value
  task automatic req(input logic [7:0] a, input logic [7:0] d, input logic w, input int gap);
    repeat (gap + 1) @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d, input int gap);
    req(a, d, 1'b1, gap);
  endtask

  task automatic read(input logic [7:0] a, input int gap, output logic [7:0] d);
    req(a, 8'h00, 1'b0, gap);
    #1;
    d = rdata;
  endtask
endmodule

// file: sim/mid_detect_core_tb_top.sv
// self-checking bench for the activity and inactivity configuration block
`include "mid_map.svh"
module mid_detect_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MF = 4;
  localparam int MS = 8;
  localparam int SF = 6;
  localparam int SS = 12;

  logic                 sys_clk, rstn, reg_wr, reg_rd, fast, xy_over, z_use, sv;
  logic                 act_ev, still_ev, mot_act, still_act;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata, z_hi, q, d;
  logic [2:0]           z_lo;
  logic [15:0]          still_dur;
  mid_pkg::mid_sample_t xs, ys, zs;
  int                   bad_count, tests_run, cyc, k, held, p, z, a, f, n;
  logic [7:0]           regm [8'h27:8'h2F];

  mid_detect_core #(
    .MOTION_FAST_CYC (MF),
    .MOTION_SLOW_CYC (MS),
    .STILL_FAST_CYC  (SF),
    .STILL_SLOW_CYC  (SS)
  ) mid_detect_core_inst (
    .SYS_CLK                 (sys_clk),
    .RSTN                    (rstn),
    .REG_ADDR                (reg_addr),
    .REG_WDATA               (reg_wdata),
    .REG_WR                  (reg_wr),
    .REG_RD                  (reg_rd),
    .REG_RDATA               (reg_rdata),
    .OUTPUT_SAMPLE_RATE_FAST (fast),
    .Z_MOTION_LIMIT_HIGH     (z_hi),
    .XY_MOTION_OVER          (xy_over),
    .Z_STILL_LIMIT_LOW       (z_lo),
    .Z_STILL_AXIS_USE        (z_use),
    .STILL_DURATION_VALUE    (still_dur),
    .SAMPLE_VALID            (sv),
    .X_SAMPLE                (xs),
    .Y_SAMPLE                (ys),
    .Z_SAMPLE                (zs),
    .ACTIVITY_EVENT          (act_ev),
    .INACTIVITY_EVENT        (still_ev),
    .MOTION_ACTIVE           (mot_act),
    .STILL_ACTIVE            (still_act)
  );

  mid_host_model mid_host_model_inst (
    .clk   (sys_clk),
    .rdata (reg_rdata),
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .wr    (reg_wr),
    .rd    (reg_rd)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // cut a hang short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [7:0] msk(input logic [7:0] ad);
    case (ad)
      `MID_ADDR_Z_MOTION_LOW, `MID_ADDR_Y_STILL_LOW: msk = `MID_MASK_LIM_USE;
      `MID_ADDR_X_STILL_LOW:                         msk = `MID_MASK_LIM_REF_USE;
      `MID_ADDR_MOTION_DUR, `MID_ADDR_X_STILL_HIGH, `MID_ADDR_Y_STILL_HIGH,
      `MID_ADDR_Z_STILL_HIGH:                        msk = 8'hFF;
      default:                                       msk = 8'h00;
    endcase
  endfunction

  // returns on the edge that takes the sample
  task automatic samp(input int x, input int y, input int zz);
    @(posedge sys_clk);
    sv <= 1'b1;
    xs <= 12'(x);
    ys <= 12'(y);
    zs <= 12'(zz);
    @(posedge sys_clk);
    sv <= 1'b0;
  endtask

  // cycles from the taking edge to the pulse, 0 if none within lim
  task automatic wait_ev(input logic act, input int lim, output int kk);
    kk = 0;
    for (int i = 1; i <= lim && kk == 0; i++)
    begin
      // read at the edge: the value launched by the edge before
      @(posedge sys_clk);
      if ((act ? act_ev : still_ev) === 1'b1)
        kk = i;
    end
  endtask

  // rearm with a failing sample in absolute mode, then apply the case sample
  task automatic still_case(input logic [7:0] c2b, input logic [7:0] c2d, input logic zu,
                            input int x, input int y, input int zz, input logic ev);
    int k1;
    mid_host_model_inst.write(`MID_ADDR_X_STILL_LOW, c2b & 8'hFD, 0);
    mid_host_model_inst.write(`MID_ADDR_Y_STILL_LOW, c2d, 0);
    z_use <= zu;
    samp(300, 300, 300);
    wait_ev(1'b0, 2, k1);
    mid_host_model_inst.write(`MID_ADDR_X_STILL_LOW, c2b, 0);
    samp(x, y, zz);
    wait_ev(1'b0, 2 * SF + 4, k1);
    check(16'(k1), ev ? 16'(2 * SF + 1) : 16'h0000);
    check(16'(still_act), 16'(ev));
  endtask

  initial
  begin
    {rstn, fast, xy_over, z_use, sv} = 5'b01000;
    z_hi = 8'h00;
    z_lo = 3'b001;
    still_dur = 16'h0002;
    xs = '0;
    ys = '0;
    zs = '0;
    void'($urandom(40));
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    for (a = 8'h27; a <= 8'h2F; a++)
    begin
      mid_host_model_inst.read(8'(a), 0, q);
      check(q, 8'h00);
    end
    $display("test reset values done");

    for (a = 8'h27; a <= 8'h2F; a++)
    begin
      d = 8'($urandom);
      mid_host_model_inst.write(8'(a), d, a % 2);
      regm[a] = d & msk(8'(a));
    end
    for (a = 8'h2F; a >= 8'h27; a--)
    begin
      mid_host_model_inst.read(8'(a), $urandom_range(0, 2), q);
      check(q, regm[a]);
    end
    $display("test register access done");

    mid_host_model_inst.write(`MID_ADDR_Z_MOTION_LOW, 8'hA1, 0);
    mid_host_model_inst.write(`MID_ADDR_MOTION_DUR, 8'h00, 0);
    held = 0;
    for (int i = 0; i < 10; i++)
    begin
      z = $urandom_range(0, 20) - 10;
      samp(0, 0, z);
      wait_ev(1'b1, 2, k);
      check(16'(k), 16'((z > 5 || z < -5) && held == 0));
      held = (z > 5 || z < -5);
      check(16'(mot_act), 16'(held));
    end
    mid_host_model_inst.write(`MID_ADDR_Z_MOTION_LOW, 8'hA0, 0);
    samp(0, 0, 0);
    samp(0, 0, 100);
    wait_ev(1'b1, 3, k);
    check(16'(k), 16'h0000);
    xy_over <= 1'b1;
    samp(0, 0, 0);
    wait_ev(1'b1, 2, k);
    check(16'(k), 16'h0001);
    xy_over <= 1'b0;
    $display("test activity limit done");

    mid_host_model_inst.write(`MID_ADDR_Z_MOTION_LOW, 8'hA1, 0);
    for (f = 1; f >= 0; f--)
    begin
      fast <= f[0];
      p = f ? MF : MS;
      for (n = 1; n <= 3; n += 2)
      begin
        mid_host_model_inst.write(`MID_ADDR_MOTION_DUR, 8'(n), 0);
        mid_host_model_inst.read(`MID_ADDR_MOTION_DUR, 0, q);
        check(q, 8'(n));
        samp(0, 0, 0);
        samp(0, 0, 50);
        wait_ev(1'b1, n * p + 4, k);
        check(16'(k), 16'(n * p + 1));
      end
      samp(0, 0, 0);
      samp(0, 0, -50);
      samp(0, 0, 0);
      wait_ev(1'b1, 3 * p + 4, k);
      check(16'(k), 16'h0000);
    end
    $display("test activity timer done");

    fast <= 1'b1;
    mid_host_model_inst.write(`MID_ADDR_Z_MOTION_LOW, 8'h00, 0);
    mid_host_model_inst.write(`MID_ADDR_X_STILL_HIGH, 8'h01, 0);
    mid_host_model_inst.write(`MID_ADDR_Y_STILL_HIGH, 8'h02, 0);
    mid_host_model_inst.write(`MID_ADDR_Z_STILL_HIGH, 8'h01, 0);
    still_case(8'h41, 8'h00, 1'b0, 9, 300, 300, 1'b1);
    still_case(8'h41, 8'h00, 1'b0, -10, 300, 300, 1'b0);
    still_case(8'h43, 8'h00, 1'b0, 305, 300, 300, 1'b1);
    still_case(8'h41, 8'h00, 1'b0, 305, 300, 300, 1'b0);
    still_case(8'h41, 8'h01, 1'b0, 9, 300, 300, 1'b0);
    still_case(8'h41, 8'h01, 1'b0, 9, -15, 300, 1'b1);
    still_case(8'h40, 8'h00, 1'b0, 9, 9, 9, 1'b0);
    still_case(8'h41, 8'h01, 1'b1, 9, 15, 8, 1'b1);
    still_case(8'h41, 8'h01, 1'b1, 9, 15, 9, 1'b0);
    $display("test inactivity done");

    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    mid_host_model_inst.read(`MID_ADDR_X_STILL_LOW, 0, q);
    check(q, 8'h00);
    check(16'({act_ev, still_ev, mot_act, still_act}), 16'h0000);
    $display("test second reset done");
    final_report();
  end
endmodule
